/* hw/cmpr_defs.vh */
// Constants of the colour matrix parameter register bank
// How it works
// RULE1: Three build options: bus, ports, constants
// RULE2: Control bit0 enables, resets to 0x1
// RULE3: Enable low halts and blocks video
// RULE4: Control bit1 arms commit at vblank
// RULE5: Reset bit0 holds immediate reset while set
// RULE6: Reset bit1 resets at next vblank rise
// RULE7: Nine weights at 0x08..0x28, row major
// RULE8: Weights signed, range -4..4, scale 32768
// RULE9: Offsets signed, output width plus one
// RULE10: Every writable register reads back
// RULE11: Weights and offsets are double buffered
// RULE12: Writes hit shadow; arithmetic uses working
// RULE13: Reads return shadow, not working copy
// RULE14: Vblank rise copies shadow when armed
// RULE15: Manual reset restores all default values
// RULE16: Outputs zero while manual reset set
// RULE17: Processor reaches registers as bus master
// RULE18: Decode a 256-byte window at base
// RULE19: Working registers on video clock
// RULE20: Constant option uses clear and enable
// RULE21: One word each, unused bits zero
// RULE22: Commit crosses safely into video domain
`ifndef CMPR_DEFS_VH
`define CMPR_DEFS_VH

// Build options
`define CMPR_MODE_BUS 2'h0
`define CMPR_MODE_PORTS 2'h1
`define CMPR_MODE_CONST 2'h2

// Register offsets
`define CMPR_OFS_CTRL 8'h00
`define CMPR_OFS_RST 8'h04
`define CMPR_OFS_W11 8'h08
`define CMPR_OFS_W12 8'h0C
`define CMPR_OFS_W13 8'h10
`define CMPR_OFS_W21 8'h14
`define CMPR_OFS_W22 8'h18
`define CMPR_OFS_W23 8'h1C
`define CMPR_OFS_W31 8'h20
`define CMPR_OFS_W32 8'h24
`define CMPR_OFS_W33 8'h28
`define CMPR_OFS_BIAS_R 8'h2C
`define CMPR_OFS_BIAS_G 8'h30
`define CMPR_OFS_BIAS_B 8'h34
`define CMPR_WIN_BITS 8

// Field positions
`define CMPR_CTRL_EN_BIT 0
`define CMPR_CTRL_SEM_BIT 1
`define CMPR_RST_MAN_BIT 0
`define CMPR_RST_AUTO_BIT 1

// Reset values
`define CMPR_CTRL_RST 2'h1
`define CMPR_RSTREG_RST 2'h0
`define CMPR_W_ONE 18'h08000
`define CMPR_W_ZERO 18'h00000
`define CMPR_BIAS_RST 9'h000

// Widths
`define CMPR_OUT_W 8
`define CMPR_W_W 18
`define CMPR_B_W 9
`define CMPR_NPAR 12

// Bus timing: answer one cycle after the request
`define CMPR_ACK_LAT 1

`endif

/* hw/cmpr_vblank_commit.v */
// Vertical blank edge detection and commit strobes
`timescale 1ns/10ps
`include "cmpr_defs.vh"
module cmpr_vblank_commit (
    clk,
    rst,
    vertical_blank_input,
    update_sem,
    auto_rst_req,
    commit_pulse,
    auto_rst_pulse
);
    input wire clk;
    input wire rst;
    input wire vertical_blank_input;
    input wire update_sem;
    input wire auto_rst_req;
    output wire commit_pulse;
    output wire auto_rst_pulse;

    reg vb_q;
    wire vb_rise;

    // Previous blank level for edge detection
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            vb_q <= 1'b0;
        end else begin
            vb_q <= vertical_blank_input;
        end
    end

    assign vb_rise = vertical_blank_input & ~vb_q;
    // Commit only while semaphore armed
    assign commit_pulse = vb_rise & update_sem; // [RULE14] [RULE4] [RULE22]
    // Synchronised reset at the same edge
    assign auto_rst_pulse = vb_rise & auto_rst_req; // [RULE6]
endmodule // cmpr_vblank_commit

/* hw/cmpr_param_regs.v */
// Colour matrix parameter bank with bus slave and double buffering
`timescale 1ns/10ps
`include "cmpr_defs.vh"
module cmpr_param_regs #(
    parameter [1:0] ACCESS_MODE = `CMPR_MODE_BUS,
    parameter [31:0] BASE_ADDR = 32'h00000000,
    parameter [`CMPR_NPAR*`CMPR_W_W-1:0] DEF_PARAMS = {
        `CMPR_W_ONE, `CMPR_W_ZERO, `CMPR_W_ZERO,
        `CMPR_W_ZERO, `CMPR_W_ONE, `CMPR_W_ZERO,
        `CMPR_W_ZERO, `CMPR_W_ZERO, `CMPR_W_ONE,
        `CMPR_W_ZERO, `CMPR_W_ZERO, `CMPR_W_ZERO}
) (
    clk,
    rst,
    plb_pavalid,
    plb_abus,
    plb_rnw,
    plb_be,
    plb_wrdbus,
    sl_addrack,
    sl_wait,
    sl_wrdack,
    sl_wrcomp,
    sl_rddack,
    sl_rdcomp,
    sl_rddbus,
    port_params,
    port_enable,
    port_update,
    synchronous_clear,
    clock_enable,
    vertical_blank_input,
    core_enable,
    core_clear,
    weights,
    biases
);
    input wire clk;
    input wire rst;
    input wire plb_pavalid;
    input wire [31:0] plb_abus;
    input wire plb_rnw;
    input wire [3:0] plb_be;
    input wire [31:0] plb_wrdbus;
    output wire sl_addrack;
    output wire sl_wait;
    output wire sl_wrdack;
    output wire sl_wrcomp;
    output wire sl_rddack;
    output wire sl_rdcomp;
    output wire [31:0] sl_rddbus;
    input wire [`CMPR_NPAR*`CMPR_W_W-1:0] port_params;
    input wire port_enable;
    input wire port_update;
    input wire synchronous_clear;
    input wire clock_enable;
    input wire vertical_blank_input;
    output wire core_enable;
    output wire core_clear;
    output wire [9*`CMPR_W_W-1:0] weights;
    output wire [3*`CMPR_B_W-1:0] biases;

    localparam NP = `CMPR_NPAR;
    localparam WW = `CMPR_W_W;
    localparam BW = `CMPR_B_W;

    // Bus handshake state
    localparam ST_IDLE = 1'b0;
    localparam ST_ANS = 1'b1;

    reg st_q;
    reg st_d;
    reg rnw_q;
    reg [7:0] ofs_q;
    reg [3:0] be_q;
    reg [31:0] wdata_q;
    reg [31:0] rdata_q;
    reg [31:0] rdata_d;
    reg opt_en;
    reg opt_sem;

    reg [1:0] ctrl_q;
    reg [1:0] rstreg_q;
    reg [WW-1:0] shd_q [0:NP-1];
    reg [WW-1:0] wrk_q [0:NP-1];

    wire is_bus;
    wire is_port;
    wire hit;
    wire take;
    wire wr_now;
    wire [31:0] wmask;
    wire [31:0] wval;
    wire man_rst;
    wire soft_rst;
    wire sem;
    wire commit;
    wire auto_pulse;
    wire [3:0] idx;
    wire idx_ok;
    wire ans_wr;
    wire ans_rd;
    wire wr_ctrl;
    wire wr_rst;

    assign is_bus = (ACCESS_MODE == `CMPR_MODE_BUS); // [RULE1] [RULE17]
    assign is_port = (ACCESS_MODE == `CMPR_MODE_PORTS); // [RULE1]

    // Window decode on the upper address bits
    assign hit = is_bus & (plb_abus[31:`CMPR_WIN_BITS] == BASE_ADDR[31:`CMPR_WIN_BITS]); // [RULE18]
    assign take = plb_pavalid & hit & (st_q == ST_IDLE);

    // Request capture and answer sequencing
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (take) begin
                    st_d = ST_ANS;
                end
            end
            ST_ANS: begin
                st_d = ST_IDLE;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // Answer state register
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // Request fields captured as the request is taken
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rnw_q <= 1'b0;
            ofs_q <= 8'h00;
            be_q <= 4'h0;
            wdata_q <= 32'h00000000;
        end else begin
            if (take) begin
                rnw_q <= plb_rnw;
                ofs_q <= plb_abus[7:0];
                be_q <= plb_be;
                wdata_q <= plb_wrdbus;
            end
        end
    end

    // Answer cycle split by direction
    assign ans_wr = (st_q == ST_ANS) & ~rnw_q;
    assign ans_rd = (st_q == ST_ANS) & rnw_q;

    // Handshake outputs, one cycle after the request
    assign sl_addrack = (st_q == ST_ANS); // [RULE17]
    assign sl_wait = 1'b0;
    assign sl_wrdack = ans_wr;
    assign sl_wrcomp = ans_wr;
    assign sl_rddack = ans_rd;
    assign sl_rdcomp = ans_rd;
    assign sl_rddbus = rdata_q;

    // Write happens on the answer cycle
    assign wr_now = ans_wr;
    assign wr_ctrl = wr_now & (ofs_q == `CMPR_OFS_CTRL);
    assign wr_rst = wr_now & (ofs_q == `CMPR_OFS_RST);
    assign wmask = {{8{be_q[3]}}, {8{be_q[2]}}, {8{be_q[1]}}, {8{be_q[0]}}};
    assign wval = wdata_q & wmask;

    // Parameter index, valid for 0x08..0x34 aligned words
    assign idx = ofs_q[5:2] - 4'h2;
    assign idx_ok = (ofs_q[1:0] == 2'h0) & (ofs_q >= `CMPR_OFS_W11) & (ofs_q <= `CMPR_OFS_BIAS_B); // [RULE7]

    // Reset sources: manual bit held, or clear input in the port and constant options
    assign man_rst = rstreg_q[`CMPR_RST_MAN_BIT] | (~is_bus & synchronous_clear); // [RULE5] [RULE20]
    assign soft_rst = man_rst | auto_pulse; // [RULE6]
    assign sem = opt_sem; // [RULE4]

    // Build option picks the enable and semaphore source
    always @* begin
        opt_en = clock_enable;
        opt_sem = 1'b0;
        case (ACCESS_MODE)
            `CMPR_MODE_BUS: begin
                opt_en = ctrl_q[`CMPR_CTRL_EN_BIT]; // [RULE2]
                opt_sem = ctrl_q[`CMPR_CTRL_SEM_BIT];
            end
            `CMPR_MODE_PORTS: begin
                opt_en = port_enable;
                opt_sem = port_update;
            end
            default: begin
                opt_en = clock_enable; // [RULE20]
                opt_sem = 1'b0;
            end
        endcase
    end

    // Control register
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `CMPR_CTRL_RST; // [RULE2]
        end else if (soft_rst) begin
            ctrl_q <= `CMPR_CTRL_RST; // [RULE15]
        end else if (wr_ctrl) begin
            ctrl_q <= (ctrl_q & ~wmask[1:0]) | wval[1:0]; // [RULE21]
        end
    end

    // Reset register; the auto bit clears once the reset has fired
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rstreg_q <= `CMPR_RSTREG_RST; // [RULE5]
        end else if (wr_rst) begin
            rstreg_q <= (rstreg_q & ~wmask[1:0]) | wval[1:0];
        end else if (auto_pulse) begin
            rstreg_q[`CMPR_RST_AUTO_BIT] <= 1'b0; // [RULE6]
        end
    end

    // Blank edge and commit strobes
    cmpr_vblank_commit u_commit (
        .clk(clk),
        .rst(rst),
        .vertical_blank_input(vertical_blank_input),
        .update_sem(sem),
        .auto_rst_req(rstreg_q[`CMPR_RST_AUTO_BIT]),
        .commit_pulse(commit),
        .auto_rst_pulse(auto_pulse)
    );

    // Shadow and working copies, one entry per parameter
    genvar g;
    generate
        for (g = 0; g < NP; g = g + 1) begin : g_par
            // Offsets keep only their narrower field
            localparam [WW-1:0] MASK_C = (g < 9) ? {WW{1'b1}} : {{(WW-BW){1'b0}}, {BW{1'b1}}}; // [RULE9] [RULE8]
            localparam [WW-1:0] DEF_C = DEF_PARAMS[(NP-1-g)*WW +: WW] & MASK_C; // [RULE7]
            wire [WW-1:0] def_v;
            wire [WW-1:0] fld;
            wire [WW-1:0] fmask;
            wire wr_sel;
            assign def_v = DEF_C;
            assign fmask = MASK_C;
            assign fld = (shd_q[g] & ~wmask[WW-1:0]) | wval[WW-1:0];
            assign wr_sel = wr_now & idx_ok & ({28'h0000000, idx} == g);

            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    shd_q[g] <= DEF_C; // [RULE7]
                end else if (soft_rst | ~(is_bus | is_port)) begin
                    shd_q[g] <= def_v & fmask; // [RULE15] [RULE20]
                end else if (is_port) begin
                    shd_q[g] <= port_params[(NP-1-g)*WW +: WW] & fmask; // [RULE1]
                end else if (wr_sel) begin
                    shd_q[g] <= fld & fmask; // [RULE12]
                end
            end

            // Working copy loads on an armed commit, or every cycle in the constant option
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    wrk_q[g] <= DEF_C; // [RULE7]
                end else if (soft_rst) begin
                    wrk_q[g] <= def_v & fmask; // [RULE15]
                end else if (commit | ~(is_bus | is_port)) begin
                    wrk_q[g] <= shd_q[g]; // [RULE11] [RULE14] [RULE19]
                end
            end

            // Arithmetic sees working values, zero under manual reset
            if (g < 9) begin : g_w
                assign weights[(8-g)*WW +: WW] = man_rst ? {WW{1'b0}} : wrk_q[g]; // [RULE12] [RULE16]
            end else begin : g_b
                assign biases[(11-g)*BW +: BW] = man_rst ? {BW{1'b0}} : wrk_q[g][BW-1:0]; // [RULE16]
            end
        end
    endgenerate

    // Read data: shadow copies, unused bits zero
    always @* begin
        rdata_d = 32'h00000000;
        case (ofs_q)
            `CMPR_OFS_CTRL: begin
                rdata_d = {30'h0, ctrl_q}; // [RULE10]
            end
            `CMPR_OFS_RST: begin
                rdata_d = {30'h0, rstreg_q};
            end
            `CMPR_OFS_W11: begin
                rdata_d = {14'h0, shd_q[0]}; // [RULE13] [RULE21]
            end
            `CMPR_OFS_W12: begin
                rdata_d = {14'h0, shd_q[1]};
            end
            `CMPR_OFS_W13: begin
                rdata_d = {14'h0, shd_q[2]};
            end
            `CMPR_OFS_W21: begin
                rdata_d = {14'h0, shd_q[3]};
            end
            `CMPR_OFS_W22: begin
                rdata_d = {14'h0, shd_q[4]};
            end
            `CMPR_OFS_W23: begin
                rdata_d = {14'h0, shd_q[5]};
            end
            `CMPR_OFS_W31: begin
                rdata_d = {14'h0, shd_q[6]};
            end
            `CMPR_OFS_W32: begin
                rdata_d = {14'h0, shd_q[7]};
            end
            `CMPR_OFS_W33: begin
                rdata_d = {14'h0, shd_q[8]};
            end
            `CMPR_OFS_BIAS_R: begin
                rdata_d = {14'h0, shd_q[9]}; // [RULE9]
            end
            `CMPR_OFS_BIAS_G: begin
                rdata_d = {14'h0, shd_q[10]};
            end
            `CMPR_OFS_BIAS_B: begin
                rdata_d = {14'h0, shd_q[11]};
            end
            default: begin
                rdata_d = 32'h00000000;
            end
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
        end else if (take & plb_rnw) begin
            rdata_q <= 32'h00000000;
        end else if (ans_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 32'h00000000;
        end
    end

    // Processing enable: register bit, port, or clock enable input
    assign core_enable = ~man_rst & opt_en; // [RULE3] [RULE20]
    assign core_clear = man_rst; // [RULE16]
endmodule // cmpr_param_regs

/* tb/cmpr_param_regs_properties.sv */
// Port checker for the colour matrix parameter bank
`timescale 1ns/10ps
module cmpr_param_regs_properties #(parameter [31:0] BASE_ADDR = 32'h00000000) (
    input wire clk,
    input wire rst,
    input wire plb_pavalid,
    input wire [31:0] plb_abus,
    input wire sl_addrack,
    input wire sl_wait,
    input wire sl_wrdack,
    input wire sl_wrcomp,
    input wire sl_rddack,
    input wire sl_rdcomp,
    input wire [31:0] sl_rddbus,
    input wire vertical_blank_input,
    input wire core_enable,
    input wire core_clear,
    input wire [161:0] weights,
    input wire [26:0] biases
);
    reg vb_q;
    reg [2:0] rise_age_q;
    // Cycles since the last vblank rise, saturating
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            vb_q <= 1'b0;
            rise_age_q <= 3'h7;
        end else begin
            vb_q <= vertical_blank_input;
            rise_age_q <= (vertical_blank_input && !vb_q) ? 3'h0 : (rise_age_q == 3'h7 ? 3'h7 : rise_age_q + 3'h1);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_req;
        $rose(plb_pavalid) && plb_abus[31:8] == BASE_ADDR[31:8] && !sl_addrack;
    endsequence
    sequence s_wr_ans;
        sl_addrack && sl_wrcomp && !sl_rddack;
    endsequence
    a_req_answered: assert property (s_req |=> sl_addrack) else $error("request not answered");
    a_ack_single: assert property (sl_addrack |=> !sl_addrack) else $error("ack longer than one cycle");
    a_write_ack_pair: assert property (sl_wrdack |-> s_wr_ans) else $error("write ack incomplete");
    a_read_ack_pair: assert property (sl_rddack |-> sl_addrack && sl_rdcomp && !sl_wrdack)
        else $error("read ack incomplete");
    a_ack_has_kind: assert property (sl_addrack |-> sl_wrdack || sl_rddack) else $error("ack without kind");
    a_wait_idle: assert property (!sl_wait) else $error("wait raised");
    a_rdata_idle: assert property (!$past(sl_rddack) |-> sl_rddbus == 32'h0) else $error("read bus not idle");
    a_clear_zero: assert property (core_clear |-> weights == 162'h0 && biases == 27'h0 && !core_enable)
        else $error("outputs live in reset");
    a_work_hold: assert property ($changed(weights) && !core_clear && !$past(core_clear) |-> rise_age_q <= 3'h3)
        else $error("working copy moved off vblank");
endmodule // cmpr_param_regs_properties
bind cmpr_param_regs cmpr_param_regs_properties #(.BASE_ADDR(BASE_ADDR)) i_cmpr_param_regs_properties (
    .clk(clk), .rst(rst), .plb_pavalid(plb_pavalid), .plb_abus(plb_abus), .sl_addrack(sl_addrack),
    .sl_wait(sl_wait), .sl_wrdack(sl_wrdack), .sl_wrcomp(sl_wrcomp), .sl_rddack(sl_rddack),
    .sl_rdcomp(sl_rdcomp), .sl_rddbus(sl_rddbus), .vertical_blank_input(vertical_blank_input),
    .core_enable(core_enable), .core_clear(core_clear), .weights(weights), .biases(biases));

/* tb/cmpr_plb_master.sv */
// Processor bus master model driving the parameter bank
`timescale 1ns/10ps
module cmpr_plb_master (
    input wire clk,
    output reg plb_pavalid,
    output reg [31:0] plb_abus,
    output reg plb_rnw,
    output reg [3:0] plb_be,
    output reg [31:0] plb_wrdbus,
    input wire sl_addrack,
    input wire [31:0] sl_rddbus
);
    integer n;
    initial begin
        plb_pavalid = 1'b0;
        plb_abus = 32'hFFFFFFFF;
        plb_rnw = 1'b1;
        plb_be = 4'h0;
        plb_wrdbus = 32'h0;
    end
    // Request held from a falling edge through the ack edge, then released
    task xfer(input r, input [31:0] a, input [31:0] d, input [3:0] b, output [31:0] q, output ack);
        begin
            @(negedge clk);
            plb_pavalid = 1'b1;
            plb_abus = a;
            plb_rnw = r;
            plb_be = b;
            plb_wrdbus = d;
            ack = 1'b0;
            for (n = 0; n < 8 && !ack; n = n + 1) begin
                @(negedge clk);
                ack = (sl_addrack === 1'b1);
            end
            @(negedge clk);
            q = sl_rddbus;
            plb_pavalid = 1'b0;
            plb_abus = ~a;
            plb_wrdbus = ~d;
        end
    endtask
endmodule // cmpr_plb_master

/* tb/tb_top.sv */
// Self-checking bench for the colour matrix parameter bank
`timescale 1ns/10ps
module tb_top;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg vb = 1'b0;
    wire pav, rnw, ack, wt, wa, wc, ra, rc, en, clr;
    wire [31:0] abus, wd, rbus;
    wire [3:0] be;
    wire [161:0] weights;
    wire [26:0] biases;
    reg [17:0] sh [0:11];
    reg [31:0] rd, v;
    reg ok;
    integer miscompares = 0;
    integer checked = 0;
    integer i;
    always #5 clk = ~clk;
    cmpr_param_regs i_cmpr_param_regs (.clk(clk), .rst(rst), .plb_pavalid(pav), .plb_abus(abus), .plb_rnw(rnw),
        .plb_be(be), .plb_wrdbus(wd), .sl_addrack(ack), .sl_wait(wt), .sl_wrdack(wa), .sl_wrcomp(wc),
        .sl_rddack(ra), .sl_rdcomp(rc), .sl_rddbus(rbus), .port_params(216'h0), .port_enable(1'b0),
        .port_update(1'b0), .synchronous_clear(1'b0), .clock_enable(1'b1), .vertical_blank_input(vb),
        .core_enable(en), .core_clear(clr), .weights(weights), .biases(biases));
    cmpr_plb_master i_cmpr_plb_master (.clk(clk), .plb_pavalid(pav), .plb_abus(abus), .plb_rnw(rnw),
        .plb_be(be), .plb_wrdbus(wd), .sl_addrack(ack), .sl_rddbus(rbus));
    // Constant build option, steered by clear and clock enable
    reg sclr = 1'b0;
    reg cen = 1'b0;
    wire en_c, clr_c;
    wire [161:0] weights_c;
    wire [26:0] biases_c;
    cmpr_param_regs #(.ACCESS_MODE(2'h2)) i_cmpr_param_regs_const (.clk(clk), .rst(rst), .plb_pavalid(1'b0),
        .plb_abus(32'h0), .plb_rnw(1'b1), .plb_be(4'h0), .plb_wrdbus(32'h0), .sl_addrack(), .sl_wait(),
        .sl_wrdack(), .sl_wrcomp(), .sl_rddack(), .sl_rdcomp(), .sl_rddbus(), .port_params(216'h0),
        .port_enable(1'b0), .port_update(1'b0), .synchronous_clear(sclr), .clock_enable(cen),
        .vertical_blank_input(vb), .core_enable(en_c), .core_clear(clr_c), .weights(weights_c), .biases(biases_c));
    // Verdict and end of run
    task wrap_up;
        begin
            $display("checked %0d miscompares %0d", checked, miscompares);
            if (miscompares == 0 && checked > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task chk_reg(input [63:0] name, input [31:0] exp, input [31:0] got);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("mismatch %0s exp %h got %h", name, exp, got);
            end
        end
    endtask
    task chk_out(input [63:0] name, input [190:0] exp);
        begin
            checked = checked + 1;
            if ({en, clr, weights, biases} !== exp) begin
                miscompares = miscompares + 1;
                $display("mismatch %0s exp %h got %h", name, exp, {en, clr, weights, biases});
            end
        end
    endtask
    task chk_cst(input [63:0] name, input [190:0] exp);
        begin
            checked = checked + 1;
            if ({en_c, clr_c, weights_c, biases_c} !== exp) begin
                miscompares = miscompares + 1;
                $display("mismatch %0s exp %h got %h", name, exp, {en_c, clr_c, weights_c, biases_c});
            end
        end
    endtask
    task bus(input r, input [31:0] a, input [31:0] d, input [3:0] b);
        begin
            i_cmpr_plb_master.xfer(r, a, d, b, rd, ok);
            if (!ok) begin
                miscompares = miscompares + 1;
                $display("mismatch ack exp 1 got 0");
                wrap_up;
            end
        end
    endtask
    task rdc(input [63:0] name, input [31:0] a, input [31:0] exp);
        begin
            bus(1'b1, a, 32'h0, 4'hF);
            chk_reg(name, exp, rd);
        end
    endtask
    task vblank;
        begin
            @(negedge clk) vb = 1'b1;
            repeat (4) @(negedge clk);
            vb = 1'b0;
            repeat (4) @(negedge clk);
        end
    endtask
    function [17:0] dflt(input integer k);
        dflt = (k % 4 == 0 && k < 9) ? 18'h08000 : 18'h00000;
    endfunction
    // Packed working copy expected from the shadow model or from the defaults
    function [188:0] work(input integer use_dflt);
        integer k;
        reg [17:0] e;
        begin
            work = 189'h0;
            for (k = 0; k < 12; k = k + 1) begin
                e = use_dflt ? dflt(k) : sh[k];
                work = k < 9 ? {work[170:0], e} : {work[179:0], e[8:0]};
            end
        end
    endfunction
    // Main sequence
    initial begin
        v = $urandom(83);
        repeat (16) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        for (i = 0; i < 12; i = i + 1)
            sh[i] = dflt(i);
        chk_out("rst_out", {2'b10, work(1)});
        rdc("ctrl", 32'h0, 32'h1);
        rdc("rstreg", 32'h4, 32'h0);
        for (i = 0; i < 12; i = i + 1)
            rdc("dflt", 32'h8 + 4 * i, {14'h0, sh[i]});
        for (i = 0; i < 12; i = i + 1) begin
            v = $urandom;
            bus(1'b0, 32'h8 + 4 * i, v, 4'hF);
            sh[i] = i < 9 ? v[17:0] : {9'h0, v[8:0]};
        end
        v = $urandom;
        bus(1'b0, 32'h8, v, 4'h1);
        sh[0][7:0] = v[7:0];
        for (i = 0; i < 12; i = i + 1)
            rdc("shadow", 32'h8 + 4 * i, {14'h0, sh[i]});
        vblank;
        chk_out("no_sem", {2'b10, work(1)});
        bus(1'b0, 32'h0, 32'h3, 4'hF);
        rdc("ctrl", 32'h0, 32'h3);
        vblank;
        chk_out("commit", {2'b10, work(0)});
        bus(1'b0, 32'h0, 32'h2, 4'hF);
        chk_out("disabled", {2'b00, work(0)});
        bus(1'b0, 32'h80, 32'hFFFFFFFF, 4'hF);
        rdc("unmapped", 32'h80, 32'h0);
        i_cmpr_plb_master.xfer(1'b1, 32'h100, 32'h0, 4'hF, rd, ok);
        chk_reg("outside", 32'h0, {31'h0, ok});
        bus(1'b0, 32'h4, 32'h1, 4'hF);
        chk_out("man_rst", {2'b01, 189'h0});
        for (i = 0; i < 12; i = i + 1)
            sh[i] = dflt(i);
        rdc("ctrl", 32'h0, 32'h1);
        rdc("rstreg", 32'h4, 32'h1);
        rdc("w33", 32'h28, {14'h0, sh[8]});
        bus(1'b0, 32'h4, 32'h0, 4'hF);
        chk_out("released", {2'b10, work(0)});
        bus(1'b0, 32'h14, $urandom, 4'hF);
        bus(1'b0, 32'h4, 32'h2, 4'hF);
        vblank;
        rdc("auto_w21", 32'h14, 32'h0);
        rdc("rstreg", 32'h4, 32'h0);
        cen = 1'b1;
        @(negedge clk);
        chk_cst("cst_on", {2'b10, work(1)});
        sclr = 1'b1;
        @(negedge clk);
        chk_cst("cst_clr", {2'b01, 189'h0});
        sclr = 1'b0;
        cen = 1'b0;
        @(negedge clk);
        chk_cst("cst_off", {2'b00, work(1)});
        wrap_up;
    end
endmodule // tb_top
